// ==== hdl/dets_pkg.sv ====
package dets_pkg;

  // variant selection: small image holds 5 entries, large image 15
  localparam logic [0:0] VARIANT_SMALL = 1'h0;
  localparam logic [0:0] VARIANT_LARGE = 1'h1;
  localparam int unsigned DEPTH_SMALL = 5;
  localparam int unsigned DEPTH_LARGE = 15;
  localparam int unsigned ENTRY_BYTES = 4;
  localparam int unsigned IMAGE_BYTES_MAX = DEPTH_LARGE * ENTRY_BYTES;

  // fixed image length readings
  localparam logic [7:0] IN_LEN_SMALL = 8'h14;
  localparam logic [7:0] IN_LEN_LARGE = 8'h3C;
  localparam logic [7:0] OUT_LEN = 8'h00;

  // parameter byte indices on the parameter port
  localparam logic [2:0] IDX_IN_LEN = 3'h0;
  localparam logic [2:0] IDX_OUT_LEN = 3'h1;
  localparam logic [2:0] IDX_DLY0 = 3'h2;
  localparam logic [2:0] IDX_DLY1 = 3'h3;
  localparam logic [2:0] IDX_RISE = 3'h4;
  localparam logic [2:0] IDX_FALL = 3'h5;

  // reset values
  localparam logic [7:0] DLY_RESET = 8'h02;
  localparam logic [7:0] EDGE_RESET = 8'h00;

  // filter delay codes
  localparam logic [7:0] DLY_CODE_1US = 8'h00;
  localparam logic [7:0] DLY_CODE_3US = 8'h02;
  localparam logic [7:0] DLY_CODE_10US = 8'h04;
  localparam logic [7:0] DLY_CODE_86US = 8'h07;
  localparam logic [7:0] DLY_CODE_342US = 8'h09;
  localparam logic [7:0] DLY_CODE_2731US = 8'h0C;

  // timing: microseconds per code and clock rate
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int unsigned DLY_1US = 1;
  localparam int unsigned DLY_3US = 3;
  localparam int unsigned DLY_10US = 10;
  localparam int unsigned DLY_86US = 86;
  localparam int unsigned DLY_342US = 342;
  localparam int unsigned DLY_2731US = 2731;
  localparam int unsigned US_CNT_W = 12;

  // entry layout: tick in bits 29:0, first input bit 30, second input bit 31
  localparam int unsigned TICK_W = 30;
  localparam int unsigned POS_IN0 = 30;
  localparam int unsigned POS_IN1 = 31;

  typedef struct packed {
    logic in1;
    logic in0;
    logic [TICK_W-1:0] tick;
  } dets_entry_s;

  typedef struct packed {
    logic wr;
    logic [2:0] idx;
    logic [7:0] data;
  } dets_par_req_s;

endpackage : dets_pkg

// ==== hdl/dets_core.sv ====
`timescale 1ns/1ps
// How it works
// - the small variant reports a 20-byte image and keeps at most five entries.
// - the large variant reports a 60-byte image and keeps at most fifteen entries.
// - the input image length reads 14h or 3Ch according to the variant and cannot be written.
// - the output image length always reads zero.
// - each channel filters its input with a delay chosen by code, default 02h, codes other than 00h, 02h, 04h, 07h, 09h and 0Ch not allowed.
// - an enabled edge stores the microsecond tick and both input states as one entry.
// - rising capture enable byte has bit 0 for the first input and bit 1 for the second.
// - rising and falling enables are separate bytes that reset to zero.
// - every new entry lands at image offset zero.
// - inserting an entry moves older ones four bytes up.
// - both channels share one buffer in arrival order.
// - when full, a new capture drops the oldest entry.
module dets_core
  import dets_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_variant,
  input wire logic i_first_input,
  input wire logic i_second_input,
  input wire logic [31:0] i_us_tick,
  input wire dets_par_req_s i_par_req,
  input wire logic [5:0] i_image_addr,
  output logic [7:0] o_par_rdata,
  output logic [7:0] o_image_rdata,
  output logic [3:0] o_entry_count,
  output logic [1:0] o_filtered,
  output logic o_capture_pulse,
  output logic o_bad_code
);

  // microseconds for a delay code, zero marks a forbidden code
  function automatic logic [US_CNT_W-1:0] dly_us(input logic [7:0] code);
    unique case (code)
      DLY_CODE_1US: dly_us = US_CNT_W'(DLY_1US);
      DLY_CODE_3US: dly_us = US_CNT_W'(DLY_3US);
      DLY_CODE_10US: dly_us = US_CNT_W'(DLY_10US);
      DLY_CODE_86US: dly_us = US_CNT_W'(DLY_86US);
      DLY_CODE_342US: dly_us = US_CNT_W'(DLY_342US);
      DLY_CODE_2731US: dly_us = US_CNT_W'(DLY_2731US);
      default: dly_us = '0;
    endcase
  endfunction : dly_us

  logic [7:0] dly0_ff;
  logic [7:0] dly1_ff;
  logic [7:0] rise_en_ff;
  logic [7:0] fall_en_ff;
  logic variant_ff;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] filt_ff;
  logic [US_CNT_W-1:0] stab_cnt_ff [2];
  logic [4:0] us_div_ff;
  logic us_stb;
  dets_entry_s image_ff [DEPTH_LARGE];
  logic [3:0] count_ff;
  logic [3:0] depth;
  logic [1:0] nxt_filt;
  logic [1:0] rise_hit;
  logic [1:0] fall_hit;
  logic capture;

  // variant is a strap, caught on clock edges after reset release
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      variant_ff <= VARIANT_SMALL;
    end else begin
      variant_ff <= i_variant;
    end
  end

  assign depth = (variant_ff == VARIANT_LARGE) ? 4'(DEPTH_LARGE) : 4'(DEPTH_SMALL);

  // parameter writes; the length bytes are read-only
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      dly0_ff <= DLY_RESET;
      dly1_ff <= DLY_RESET;
      rise_en_ff <= EDGE_RESET;
      fall_en_ff <= EDGE_RESET;
    end else if (i_par_req.wr) begin
      unique case (i_par_req.idx)
        IDX_DLY0: dly0_ff <= i_par_req.data;
        IDX_DLY1: dly1_ff <= i_par_req.data;
        IDX_RISE: rise_en_ff <= {6'h00, i_par_req.data[1:0]}; // reserved bits stay zero
        IDX_FALL: fall_en_ff <= {6'h00, i_par_req.data[1:0]};
        default: ;
      endcase
    end
  end

  // parameter read mux
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_par_rdata <= 8'h00;
    end else begin
      unique case (i_par_req.idx)
        IDX_IN_LEN: o_par_rdata <= (variant_ff == VARIANT_LARGE) ? IN_LEN_LARGE : IN_LEN_SMALL;
        IDX_OUT_LEN: o_par_rdata <= OUT_LEN;
        IDX_DLY0: o_par_rdata <= dly0_ff;
        IDX_DLY1: o_par_rdata <= dly1_ff;
        IDX_RISE: o_par_rdata <= rise_en_ff;
        IDX_FALL: o_par_rdata <= fall_en_ff;
        default: o_par_rdata <= 8'h00;
      endcase
    end
  end

  // forbidden delay code flag; filter then falls back to the shortest delay
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_bad_code <= 1'b0;
    end else begin
      o_bad_code <= (dly_us(dly0_ff) == '0) || (dly_us(dly1_ff) == '0);
    end
  end

  // pins pass two flops before use
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else begin
      sync1_ff <= {i_second_input, i_first_input};
      sync2_ff <= sync1_ff;
    end
  end

  // one-microsecond enable from the system clock
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      us_div_ff <= 5'h00;
    end else if (us_stb) begin
      us_div_ff <= 5'h00;
    end else begin
      us_div_ff <= us_div_ff + 5'h01;
    end
  end

  assign us_stb = (us_div_ff == 5'(CYC_PER_US - 1));

  // stability filter: level must differ on as many microsecond strobes as the delay before it is taken
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      stab_cnt_ff[0] <= '0;
      stab_cnt_ff[1] <= '0;
      filt_ff <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (sync2_ff[ch] == filt_ff[ch]) begin
          stab_cnt_ff[ch] <= '0;
        end else if (us_stb) begin
          if (stab_cnt_ff[ch] + US_CNT_W'(1) >= ((ch == 0) ? dly_us(dly0_ff) : dly_us(dly1_ff))) begin
            stab_cnt_ff[ch] <= '0;
            filt_ff[ch] <= sync2_ff[ch];
          end else begin
            stab_cnt_ff[ch] <= stab_cnt_ff[ch] + US_CNT_W'(1);
          end
        end
      end
    end
  end

  // next filtered level, used for edge detection in the same cycle
  always_comb begin
    nxt_filt = filt_ff;
    for (int ch = 0; ch < 2; ch++) begin
      if (sync2_ff[ch] != filt_ff[ch] && us_stb &&
          stab_cnt_ff[ch] + US_CNT_W'(1) >= ((ch == 0) ? dly_us(dly0_ff) : dly_us(dly1_ff))) begin
        nxt_filt[ch] = sync2_ff[ch];
      end
    end
  end

  // edges on filtered levels, gated per channel by the enable bytes
  assign rise_hit = nxt_filt & ~filt_ff & rise_en_ff[1:0];
  assign fall_hit = ~nxt_filt & filt_ff & fall_en_ff[1:0];
  // simultaneous edges on both channels make one entry showing both states
  assign capture = |(rise_hit | fall_hit);

  // shift image: newest at slot 0, oldest falls off past the variant depth
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < DEPTH_LARGE; i++) begin
        image_ff[i] <= '0;
      end
    end else if (capture) begin
      image_ff[0].tick <= i_us_tick[TICK_W-1:0];
      image_ff[0].in0 <= nxt_filt[0];
      image_ff[0].in1 <= nxt_filt[1];
      for (int i = 1; i < DEPTH_LARGE; i++) begin
        // slots at or beyond the variant depth are cleared so nothing stale can be read
        image_ff[i] <= (4'(i) < depth) ? image_ff[i-1] : '0;
      end
    end
  end

  // entry count saturates at the variant depth
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      count_ff <= 4'h0;
    end else if (capture && count_ff < depth) begin
      count_ff <= count_ff + 4'h1;
    end
  end

  // byte read of the image, little-endian within each entry
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_image_rdata <= 8'h00;
    end else if ({2'h0, i_image_addr} < ({4'h0, depth} << 2)) begin
      o_image_rdata <= image_ff[i_image_addr[5:2]][i_image_addr[1:0]*8 +: 8];
    end else begin
      o_image_rdata <= 8'h00;
    end
  end

  // status outputs
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_capture_pulse <= 1'b0;
    end else begin
      o_capture_pulse <= capture;
    end
  end

  assign o_entry_count = count_ff;
  assign o_filtered = filt_ff;

endmodule : dets_core

// ==== tb/dets_sva.sv ====
`timescale 1ns/1ps
module dets_sva
  import dets_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_variant,
  input wire logic i_first_input,
  input wire logic i_second_input,
  input wire logic [31:0] i_us_tick,
  input wire dets_par_req_s i_par_req,
  input wire logic [5:0] i_image_addr,
  input wire logic [7:0] o_par_rdata,
  input wire logic [7:0] o_image_rdata,
  input wire logic [3:0] o_entry_count,
  input wire logic [1:0] o_filtered,
  input wire logic o_capture_pulse,
  input wire logic o_bad_code
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // two clean cycles: the variant strap is latched one edge after release
  sequence s_settled;
    !$past(i_reset) && !$past(i_reset, 2);
  endsequence
  sequence s_bad_wr;
    i_par_req.wr && i_par_req.idx == IDX_DLY0 && i_par_req.data == 8'h05;
  endsequence
  property p_in_len;
    s_settled ##0 $past(i_par_req.idx) == IDX_IN_LEN |-> o_par_rdata == (i_variant ? IN_LEN_LARGE : IN_LEN_SMALL);
  endproperty
  a_in_len: assert property (p_in_len) else $error("input length wrong");
  property p_out_len;
    s_settled ##0 $past(i_par_req.idx) == IDX_OUT_LEN |-> o_par_rdata == OUT_LEN;
  endproperty
  a_out_len: assert property (p_out_len) else $error("output length not zero");
  property p_bad_code;
    s_bad_wr |-> ##[1:3] o_bad_code;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code not flagged");
  property p_cnt_max;
    o_entry_count <= (i_variant ? 4'hF : 4'h5);
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("count above depth");
  property p_cnt_step;
    $changed(o_entry_count) |-> o_entry_count == $past(o_entry_count) + 4'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count jumped");
  property p_cnt_pulse;
    $changed(o_entry_count) |-> ##[0:1] o_capture_pulse;
  endproperty
  a_cnt_pulse: assert property (p_cnt_pulse) else $error("entry without pulse");
  property p_pulse_one;
    o_capture_pulse |=> !o_capture_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
  property p_filt;
    $changed(o_filtered[0]) |-> $past(i_first_input, 4) == o_filtered[0];
  endproperty
  a_filt: assert property (p_filt) else $error("unfiltered change");
  property p_beyond;
    s_settled ##0 !i_variant && $past(i_image_addr) >= 6'h14 |-> o_image_rdata == 8'h00;
  endproperty
  a_beyond: assert property (p_beyond) else $error("data past image end");
endmodule : dets_sva

// ==== tb/dets_head_model.sv ====
`timescale 1ns/1ps
module dets_head_model
  import dets_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  output logic [31:0] o_us_tick
);
  logic [4:0] div_ff;
  // free tick; odd start so the dropped top bits show
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      div_ff <= 5'h00;
      o_us_tick <= 32'hC000_0100;
    end else if (div_ff == 5'(CYC_PER_US - 1)) begin
      div_ff <= 5'h00;
      o_us_tick <= o_us_tick + 32'h1;
    end else begin
      div_ff <= div_ff + 5'h01;
    end
  end
endmodule : dets_head_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import dets_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_variant = 1'b0;
  logic i_first_input = 1'b0;
  logic i_second_input = 1'b0;
  logic [31:0] i_us_tick;
  dets_par_req_s i_par_req = '0;
  logic [5:0] i_image_addr = 6'h00;
  logic [7:0] o_par_rdata, o_image_rdata, d;
  logic [3:0] o_entry_count;
  logic [1:0] o_filtered;
  logic o_capture_pulse, o_bad_code;
  logic [31:0] exp_q[$];
  logic [31:0] v, e;
  logic [7:0] rv[6] = '{IN_LEN_SMALL, OUT_LEN, DLY_RESET, DLY_RESET, EDGE_RESET, EDGE_RESET};
  logic [7:0] codes[6] = '{DLY_CODE_1US, DLY_CODE_10US, DLY_CODE_86US, DLY_CODE_342US, DLY_CODE_2731US, DLY_CODE_3US};
  int n_fail = 0;
  int checked = 0;
  dets_core dets_core_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_variant(i_variant),
    .i_first_input(i_first_input), .i_second_input(i_second_input), .i_us_tick(i_us_tick),
    .i_par_req(i_par_req), .i_image_addr(i_image_addr), .o_par_rdata(o_par_rdata),
    .o_image_rdata(o_image_rdata), .o_entry_count(o_entry_count), .o_filtered(o_filtered),
    .o_capture_pulse(o_capture_pulse), .o_bad_code(o_bad_code));
  dets_head_model dets_head_model_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .o_us_tick(i_us_tick));
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic test_done;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(string what, logic [31:0] ex, logic [31:0] got);
    checked++;
    if (got !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
    end
  endtask : chk
  // one-cycle write strobe, released at the taking edge
  task automatic par_wr(logic [2:0] idx, logic [7:0] dat);
    @(posedge i_clk_sys);
    i_par_req <= '{wr: 1'b1, idx: idx, data: dat};
    @(posedge i_clk_sys);
    i_par_req.wr <= 1'b0;
  endtask : par_wr
  task automatic par_rd(logic [2:0] idx, output logic [7:0] q);
    @(posedge i_clk_sys);
    i_par_req.idx <= idx;
    repeat (2) @(posedge i_clk_sys);
    q = o_par_rdata;
  endtask : par_rd
  // little-endian entry assembled byte by byte
  task automatic entry_rd(int n, output logic [31:0] q);
    for (int b = 0; b < 4; b++) begin
      @(posedge i_clk_sys);
      i_image_addr <= 6'(4 * n + b);
      repeat (2) @(posedge i_clk_sys);
      q[8*b+:8] = o_image_rdata;
    end
  endtask : entry_rd
  task automatic edge_in(logic ch, logic lvl, logic cap);
    logic got;
    got = 1'b0;
    @(posedge i_clk_sys);
    if (ch) i_second_input <= lvl;
    else i_first_input <= lvl;
    for (int c = 0; c < 200 && !got; c++) begin
      @(posedge i_clk_sys);
      got = (o_capture_pulse === 1'b1);
    end
    chk("capture", {31'h0, cap}, {31'h0, got});
    if (cap && !got) test_done();
    if (got) exp_q.push_front({i_second_input, i_first_input, i_us_tick[29:0]});
    repeat (3) @(posedge i_clk_sys);
    chk("count", (exp_q.size() > 5) ? 5 : exp_q.size(), {28'h0, o_entry_count});
    chk("filtered", {30'h0, i_second_input, i_first_input}, {30'h0, o_filtered});
  endtask : edge_in
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      par_rd(3'(k), d);
      chk("par reset", rv[k], d);
    end
    // length record sent while no capture is enabled, i.e. the stopped state
    par_wr(IDX_IN_LEN, 8'hFF);
    par_wr(IDX_OUT_LEN, 8'hFF);
    par_wr(IDX_RISE, 8'hFD);
    par_wr(IDX_FALL, 8'h02);
    par_rd(IDX_IN_LEN, d);
    chk("in len", IN_LEN_SMALL, d);
    par_rd(IDX_OUT_LEN, d);
    chk("out len", OUT_LEN, d);
    par_rd(IDX_RISE, d);
    chk("rise en", 8'h01, d);
    edge_in(1'b1, 1'b1, 1'b0);
    edge_in(1'b1, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      edge_in(1'b0, 1'b1, 1'b1);
      edge_in(1'b0, 1'b0, 1'b0);
    end
    // newest first; the tick may be one behind the pulse sample
    for (int k = 0; k < 5; k++) begin
      entry_rd(k, v);
      e = exp_q[k];
      if (v[29:0] === e[29:0] - 30'h1) e[29:0] = v[29:0];
      chk("entry", e, v);
    end
    entry_rd(5, v);
    chk("beyond", 32'h0, v);
    for (int k = 0; k < 6; k++) begin
      par_wr(IDX_DLY1, codes[k]);
      repeat (3) @(posedge i_clk_sys);
      chk("good code", 32'h0, {31'h0, o_bad_code});
    end
    par_wr(IDX_DLY0, 8'h05);
    repeat (3) @(posedge i_clk_sys);
    chk("bad code", 32'h1, {31'h0, o_bad_code});
    i_variant <= 1'b1;
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    par_rd(IDX_IN_LEN, d);
    chk("large len", IN_LEN_LARGE, d);
    test_done();
  end
endmodule : tb
bind dets_core dets_sva dets_sva_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_variant(i_variant),
  .i_first_input(i_first_input), .i_second_input(i_second_input), .i_us_tick(i_us_tick),
  .i_par_req(i_par_req), .i_image_addr(i_image_addr), .o_par_rdata(o_par_rdata),
  .o_image_rdata(o_image_rdata), .o_entry_count(o_entry_count), .o_filtered(o_filtered),
  .o_capture_pulse(o_capture_pulse), .o_bad_code(o_bad_code));
